// File: dv/rcwc_ext_model.sv
// external prom programmer and reset circuit model for the controller bench
`timescale 1ns/1ns
module rcwc_ext_model
(
    // clock
    input wire logic clk,
    // programmer request
    input wire logic prog_req,
    input wire logic [13:0] prog_word,
    // reset button, high while pressed
    input wire logic press,
    // device pins
    output logic [13:0] configuration_word,
    output logic reset_pin_n
);
    initial configuration_word = 14'h3fff;
    always @(posedge clk)
    begin
        // the fast internal rc with the 2.0v threshold is never burnt
        if (prog_req && !(prog_word[9:8] == 2'h1 && prog_word[11]))
            configuration_word <= prog_word;
    end
    assign reset_pin_n = !press;
endmodule

// File: dv/tb.sv
// self-checking bench for the reset, configuration and watchdog controller
`timescale 1ns/1ns
module tb
    import rcwc_pkg::*;
;
    // shortened timer periods keep the run brief
    localparam int SC = 20;
    localparam int LC = 50;
    // decode row: word, read address, clock invalid, read blocked
    typedef struct packed {logic [13:0] w; logic [9:0] a; logic inv; logic blk;} rcwc_row_s;
    // stimulus, defined at time zero
    logic clk = 1'b0, nrst = 1'b0, below_2v0 = 1'b0, below_2v9 = 1'b0;
    logic sleep_instr = 1'b0, clear_watchdog_instr = 1'b0, wakeup_timer_irq_enable = 1'b0;
    logic long_period = 1'b0, pending_write = 1'b0, pending_wdata = 1'b0;
    logic ext_irq_pending = 1'b0, ext_irq_enable = 1'b0, prog_req = 1'b0, press = 1'b0;
    logic [13:0] prog_word = 14'h3fff;
    logic [9:0] prog_read_addr = 10'h000;
    // outputs of the model and the controller
    logic [13:0] configuration_word;
    logic reset_pin_n, sys_rst_n, sleeping, time_out_flag, power_down_flag;
    logic wakeup_timer_pending, reset_pin_level, clk_invalid, read_blocked;
    rcwc_cfg_s cfg;
    // bookkeeping
    int err_count = 0, checks = 0, n = 0;
    rcwc_row_s rows [8] = '{'{14'h3fbf, 10'h000, 1'b1, 1'b0}, '{14'h1fbf, 10'h1ff, 1'b1, 1'b1},
        '{14'h1fbf, 10'h200, 1'b1, 1'b0}, '{14'h0fbf, 10'h3fb, 1'b1, 1'b1},
        '{14'h0fbf, 10'h3fc, 1'b1, 1'b0}, '{14'h35bf, 10'h000, 1'b0, 1'b0},
        '{14'h3cbf, 10'h3fb, 1'b0, 1'b0}, '{14'h3fa0, 10'h100, 1'b1, 1'b0}};
    // low-voltage cases: word, below 2.9v, below 2.0v, reset expected
    logic [16:0] lv [5] = '{{14'h3f3f, 3'b111}, {14'h3f3f, 3'b100}, {14'h373f, 3'b101},
        {14'h333f, 3'b110}, {14'h3b3f, 3'b011}};
    // 10 mhz clock
    always #50 clk = ~clk;
    rcwc_ext_model i_rcwc_ext_model (.clk, .prog_req, .prog_word, .press,
        .configuration_word, .reset_pin_n);
    rcwc_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_rcwc_ctrl (.clk, .nrst, .configuration_word,
        .below_2v0, .below_2v9, .reset_pin_n, .sleep_instr, .clear_watchdog_instr,
        .wakeup_timer_irq_enable, .long_period, .pending_write, .pending_wdata,
        .ext_irq_pending, .ext_irq_enable, .prog_read_addr, .sys_rst_n, .sleeping,
        .time_out_flag, .power_down_flag, .wakeup_timer_pending, .reset_pin_level, .cfg,
        .clk_invalid, .read_blocked);
    // verdict, the only place the run ends
    task automatic wrap_up();
        $display("counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // single-bit compare
    task automatic chk(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    // decoded configuration compare
    task automatic chk_cfg(input rcwc_cfg_s exp, input rcwc_cfg_s got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD cfg expected %h seen %h", exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // bounded wait: 0 reset out, 1 sleeping, 2 wakeup pending
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        logic v;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            v = sel == 0 ? sys_rst_n : sel == 1 ? sleeping : wakeup_timer_pending;
        end while (v !== lvl && n < lim);
        if (v !== lvl)
        begin
            err_count++;
            $display("BAD wait %0d expected %b seen %b", sel, lvl, v);
            wrap_up();
        end
    endtask
    // one-cycle cpu pulse: 0 sleep, 1 clear watchdog, 2 pending write
    task automatic pulse(input int sel);
        @(posedge clk);
        case (sel)
            0: sleep_instr <= 1'b1;
            1: clear_watchdog_instr <= 1'b1;
            default: pending_write <= 1'b1;
        endcase
        @(posedge clk);
        sleep_instr <= 1'b0;
        clear_watchdog_instr <= 1'b0;
        pending_write <= 1'b0;
    endtask
    // burn a word; cfg is registered so allow two more edges
    task automatic prog(input logic [13:0] w);
        @(posedge clk);
        prog_req <= 1'b1;
        prog_word <= w;
        @(posedge clk);
        prog_req <= 1'b0;
        cyc(2);
    endtask
    // external interrupt ends sleep
    task automatic wake();
        @(posedge clk);
        ext_irq_enable <= 1'b1;
        ext_irq_pending <= 1'b1;
        wait_for(1, 1'b0, 4);
        @(posedge clk);
        ext_irq_enable <= 1'b0;
        ext_irq_pending <= 1'b0;
    endtask
    initial
    begin
        cyc(3);
        @(negedge clk);
        chk_cfg(13'h1fff, cfg);
        chk("rst during por", 1'b0, sys_rst_n);
        chk("to after por", 1'b0, time_out_flag);
        chk("pd after por", 1'b0, power_down_flag);
        prog(14'h3fbf);
        nrst <= 1'b1;
        wait_for(0, 1'b1, 40);
        chk("stretch", 1'b1, n >= 16);
        $display("test reset done");
        foreach (rows[i])
        begin
            prog(rows[i].w);
            prog_read_addr <= rows[i].a;
            cyc(1);
            @(negedge clk);
            chk_cfg({rows[i].w[13:6], rows[i].w[4:0]}, cfg);
            chk("clk invalid", rows[i].inv, clk_invalid);
            chk("read blocked", rows[i].blk, read_blocked);
        end
        $display("test decode done");
        // timer periods with the watchdog reset off
        prog(14'h3fbf);
        wakeup_timer_irq_enable <= 1'b1;
        long_period <= 1'b1;
        pulse(1);
        cyc(LC - 10);
        @(negedge clk);
        chk("long early", 1'b0, wakeup_timer_pending);
        wait_for(2, 1'b1, 20);
        chk("no wd reset", 1'b1, sys_rst_n);
        pending_wdata <= 1'b1;
        pulse(2);
        @(negedge clk);
        chk("write one", 1'b1, wakeup_timer_pending);
        pending_wdata <= 1'b0;
        pulse(2);
        @(negedge clk);
        chk("write zero", 1'b0, wakeup_timer_pending);
        long_period <= 1'b0;
        pulse(1);
        wait_for(2, 1'b1, SC + 6);
        chk("short period", 1'b1, n >= SC - 2);
        wakeup_timer_irq_enable <= 1'b0;
        pulse(2);
        pulse(1);
        cyc(3 * SC);
        @(negedge clk);
        chk("timer stopped", 1'b0, wakeup_timer_pending);
        $display("test timer done");
        // sleep entry, exit and timer wakeup
        pulse(0);
        @(negedge clk);
        chk("sleeping", 1'b1, sleeping);
        chk("pd set", 1'b1, power_down_flag);
        chk("to clr", 1'b0, time_out_flag);
        wake();
        wakeup_timer_irq_enable <= 1'b1;
        pulse(1);
        pulse(0);
        wait_for(1, 1'b0, SC + 8);
        pulse(1);
        @(negedge clk);
        chk("pd clr", 1'b0, power_down_flag);
        $display("test sleep done");
        // watchdog on, irq off: sleep clears and stops the timer
        wakeup_timer_irq_enable <= 1'b0;
        prog(14'h3fff);
        pulse(1);
        cyc(12);
        pulse(0);
        cyc(3 * SC);
        @(negedge clk);
        chk("sleep held", 1'b1, sleeping);
        wake();
        wait_for(0, 1'b0, SC + 8);
        chk("timer cleared", 1'b1, n >= SC - 4);
        // the flag is registered one edge after the overflow pulse
        @(negedge clk);
        chk("to set", 1'b1, time_out_flag);
        wait_for(0, 1'b1, 40);
        chk("pd kept", 1'b1, power_down_flag);
        chk("to kept", 1'b1, time_out_flag);
        pulse(1);
        @(negedge clk);
        chk("to cleared", 1'b0, time_out_flag);
        // both enabled: counting goes on through sleep
        wakeup_timer_irq_enable <= 1'b1;
        pulse(1);
        cyc(10);
        pulse(0);
        wait_for(0, 1'b0, 14);
        wait_for(0, 1'b1, 40);
        pulse(1);
        wakeup_timer_irq_enable <= 1'b0;
        $display("test watchdog done");
        // pin reset enabled, then pin as plain input
        press <= 1'b1;
        wait_for(0, 1'b0, 6);
        press <= 1'b0;
        wait_for(0, 1'b1, 40);
        pulse(1);
        prog(14'h3f3f);
        press <= 1'b1;
        cyc(6);
        @(negedge clk);
        chk("pin ignored", 1'b1, sys_rst_n);
        chk("pin level", 1'b0, reset_pin_level);
        @(posedge clk);
        press <= 1'b0;
        $display("test pin done");
        // low-voltage modes; power-down flag must be cleared by it
        pulse(0);
        wake();
        foreach (lv[i])
        begin
            prog(lv[i][16:3]);
            below_2v9 <= lv[i][2];
            below_2v0 <= lv[i][1];
            cyc(10);
            @(negedge clk);
            chk("lvr hold", !lv[i][0], sys_rst_n);
            @(posedge clk);
            below_2v9 <= 1'b0;
            below_2v0 <= 1'b0;
            wait_for(0, 1'b1, 40);
        end
        chk("lvr clears pd", 1'b0, power_down_flag);
        // mode 10 ignores the 2.0v detector only while asleep
        pulse(0);
        below_2v0 <= 1'b1;
        cyc(6);
        @(negedge clk);
        chk("lvr off asleep", 1'b1, sys_rst_n & sleeping);
        wake();
        @(negedge clk);
        chk("lvr on awake", 1'b0, sys_rst_n);
        below_2v0 <= 1'b0;
        wait_for(0, 1'b1, 40);
        $display("test low voltage done");
        wrap_up();
    end
endmodule

// File: inc/rcwc_cfg.svh
// constants for the reset, configuration and watchdog controller
`ifndef RCWC_CFG_SVH
`define RCWC_CFG_SVH
// configuration word layout
`define RCWC_CFG_W 14
`define RCWC_CFG_DEFAULT 14'h3fff
`define RCWC_CFG_ADDR 10'h3fc
`define RCWC_BIT_PROT 13
`define RCWC_BIT_SECOND 12
`define RCWC_LVR_HI 11
`define RCWC_LVR_LO 10
`define RCWC_CLK_HI 9
`define RCWC_CLK_LO 8
`define RCWC_BIT_PINRST 7
`define RCWC_BIT_WDRST 6
`define RCWC_TRIM_HI 4
`define RCWC_TRIM_LO 0
// program memory regions
`define RCWC_HALF_ADDR 10'h200
`define RCWC_RESV_ADDR 10'h3fc
// timer periods in microseconds, clock in MHz
`define RCWC_T_SHORT_US 13000
`define RCWC_T_LONG_US 131000
`define RCWC_CLK_MHZ 10
// reset stretch after all sources release, cycles
`define RCWC_RST_HOLD 8'h10
`endif

// File: inc/rcwc_pkg.sv
// types for the reset, configuration and watchdog controller
package rcwc_pkg;
    // decoded configuration word
    typedef struct packed {
        logic prot_n;
        logic second_half_n;
        logic [1:0] lvr_mode;
        logic [1:0] clk_sel;
        logic pin_rst_en;
        logic wd_rst_en;
        logic [4:0] trim;
    } rcwc_cfg_s;
    // operating mode
    typedef enum logic [1:0] {RCWC_RUN, RCWC_SLEEP, RCWC_RESET} rcwc_mode_e;
endpackage

// File: rtl/rcwc_ctrl.sv
// reset, configuration word and watchdog/sleep controller
`timescale 1ns/1ns
`include "rcwc_cfg.svh"
module rcwc_ctrl
    import rcwc_pkg::*;
#(
    parameter int SHORT_CYC = `RCWC_T_SHORT_US * `RCWC_CLK_MHZ,
    parameter int LONG_CYC = `RCWC_T_LONG_US * `RCWC_CLK_MHZ
)
(
    // clock and power-on reset
    input wire logic clk,
    input wire logic nrst,
    // configuration word from program memory
    input wire logic [13:0] configuration_word,
    // analogue comparators, asynchronous
    input wire logic below_2v0,
    input wire logic below_2v9,
    // external reset pin, active low
    input wire logic reset_pin_n,
    // cpu events
    input wire logic sleep_instr,
    input wire logic clear_watchdog_instr,
    input wire logic wakeup_timer_irq_enable,
    input wire logic long_period,
    input wire logic pending_write,
    input wire logic pending_wdata,
    input wire logic ext_irq_pending,
    input wire logic ext_irq_enable,
    // program memory read check
    input wire logic [9:0] prog_read_addr,
    // reset and mode outputs
    output logic sys_rst_n,
    output logic sleeping,
    output logic time_out_flag,
    output logic power_down_flag,
    output logic wakeup_timer_pending,
    output logic reset_pin_level,
    // configuration decodes
    output rcwc_cfg_s cfg,
    output logic clk_invalid,
    output logic read_blocked
);
    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    logic pin_s; // synchronised pin
    logic lv20_s; // synchronised 2.0V comparator
    logic lv29_s; // synchronised 2.9V comparator
    logic lvr_active; // low-voltage reset condition
    logic pin_rst; // pin reset condition
    logic wd_ovf; // timer overflow pulse
    logic wd_rst_req; // watchdog reset request
    logic timer_run; // timer oscillator running
    logic timer_clear; // timer clear strobe
    logic any_rst; // any enabled source
    logic [7:0] hold; // release stretch counter
    rcwc_mode_e mode; // run, sleep or reset
    // blank word; bit 5 has no field in the decoded struct, so it is dropped below
    localparam logic [13:0] CFG_BLANK = `RCWC_CFG_DEFAULT;

    // protection test for one address, word is the raw config
    function automatic logic is_protected(input logic [13:0] w, input logic [9:0] a);
        logic p;
        p = 1'b0;
        if (!w[`RCWC_BIT_PROT])
        begin
            if (w[`RCWC_BIT_SECOND])
                p = (a < `RCWC_HALF_ADDR);
            else
                p = (a < `RCWC_RESV_ADDR);
        end
        return p;
    endfunction

    // options from configuration word; register keeps outputs clean
    // the word is only ever written by the programmer, so it is sampled, never stored
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cfg <= {CFG_BLANK[13:6], CFG_BLANK[4:0]};
        else
        begin
            cfg.prot_n <= configuration_word[`RCWC_BIT_PROT];
            cfg.second_half_n <= configuration_word[`RCWC_BIT_SECOND];
            cfg.lvr_mode <= configuration_word[`RCWC_LVR_HI:`RCWC_LVR_LO];
            cfg.clk_sel <= configuration_word[`RCWC_CLK_HI:`RCWC_CLK_LO];
            cfg.pin_rst_en <= configuration_word[`RCWC_BIT_PINRST];
            cfg.wd_rst_en <= configuration_word[`RCWC_BIT_WDRST];
            cfg.trim <= configuration_word[`RCWC_TRIM_HI:`RCWC_TRIM_LO];
        end
    end

    // upper clock select bit marks invalid setting
    assign clk_invalid = cfg.clk_sel[1];

    // protected range follows the reuse bit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            read_blocked <= 1'b0;
        else
            read_blocked <= is_protected(configuration_word, prog_read_addr);
    end

    // ----------------------------------------------------------------
    // reset sources
    // ----------------------------------------------------------------
    rcwc_sync u_pin (.clk(clk), .nrst(nrst), .d(reset_pin_n), .q(pin_s));
    rcwc_sync u_lv20 (.clk(clk), .nrst(nrst), .d(~below_2v0), .q(lv20_s));
    rcwc_sync u_lv29 (.clk(clk), .nrst(nrst), .d(~below_2v9), .q(lv29_s));

    // pin as plain input when pin reset is off
    assign reset_pin_level = pin_s;

    // static low-voltage reset per mode; 2.0V off in sleep for mode 10
    always_comb
    begin
        case (cfg.lvr_mode)
            2'h3: lvr_active = ~lv20_s;
            2'h2: lvr_active = ~lv20_s & (mode != RCWC_SLEEP);
            2'h1: lvr_active = ~lv29_s;
            default: lvr_active = 1'b0;
        endcase
    end

    // low pin level resets when enabled
    assign pin_rst = cfg.pin_rst_en & ~pin_s;
    // overflow resets only with watchdog enabled
    assign wd_rst_req = wd_ovf & cfg.wd_rst_en;
    assign any_rst = lvr_active | pin_rst | wd_rst_req;

    // hold reset until all sources gone plus a stretch
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hold <= `RCWC_RST_HOLD;
        else if (any_rst)
            hold <= `RCWC_RST_HOLD;
        else if (hold != 8'h0)
            hold <= hold - 8'h1;
    end
    assign sys_rst_n = (hold == 8'h0) & ~any_rst;

    // ----------------------------------------------------------------
    // mode machine
    // ----------------------------------------------------------------
    // sleep entered by instruction; left on reset or irq
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mode <= RCWC_RESET;
        else
        begin
            case (mode)
                RCWC_RESET:
                    if (sys_rst_n)
                        mode <= RCWC_RUN;
                RCWC_RUN:
                    if (!sys_rst_n)
                        mode <= RCWC_RESET;
                    else if (sleep_instr)
                        mode <= RCWC_SLEEP;
                RCWC_SLEEP:
                    if (!sys_rst_n || any_rst)
                        mode <= RCWC_RESET;
                    else if ((ext_irq_pending & ext_irq_enable) ||
                             (wakeup_timer_pending & wakeup_timer_irq_enable))
                        mode <= RCWC_RUN;
                default:
                    mode <= RCWC_RESET;
            endcase
        end
    end
    assign sleeping = (mode == RCWC_SLEEP);

    // ----------------------------------------------------------------
    // shared timer
    // ----------------------------------------------------------------
    // normal mode: stop only with both disabled
    // sleep: run only with irq enable; keeps counting
    always_comb
    begin
        if (mode == RCWC_SLEEP)
            timer_run = wakeup_timer_irq_enable;
        else if (mode == RCWC_RUN)
            timer_run = cfg.wd_rst_en | wakeup_timer_irq_enable;
        else
            timer_run = 1'b0;
    end

    // clear on instruction, in reset, and on sleep entry with watchdog reset on and irq off
    assign timer_clear = clear_watchdog_instr | (mode == RCWC_RESET) |
        (sleep_instr & (mode == RCWC_RUN) & cfg.wd_rst_en & ~wakeup_timer_irq_enable);

    rcwc_timer #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_timer
    (
        .clk(clk),
        .nrst(nrst),
        .run(timer_run),
        .clear(timer_clear),
        .long_period(long_period),
        .overflow(wd_ovf)
    );

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    // time-out flag; overflow set wins over clear
    // pin and watchdog resets leave it alone
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            time_out_flag <= 1'b0;
        else if (wd_ovf & cfg.wd_rst_en)
            time_out_flag <= 1'b1;
        else if (lvr_active | clear_watchdog_instr | (sleep_instr & (mode == RCWC_RUN)))
            time_out_flag <= 1'b0;
    end

    // power-down flag; sleep set wins over clear
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            power_down_flag <= 1'b0;
        else if (sleep_instr & (mode == RCWC_RUN))
            power_down_flag <= 1'b1;
        else if (lvr_active | clear_watchdog_instr)
            power_down_flag <= 1'b0;
    end

    // wakeup pending, hardware set wins, write 0 clears
    // set by overflow when watchdog reset is off
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wakeup_timer_pending <= 1'b0;
        else if (wd_ovf & ~cfg.wd_rst_en)
            wakeup_timer_pending <= 1'b1;
        else if (!sys_rst_n)
            wakeup_timer_pending <= 1'b0;
        else if (pending_write & ~pending_wdata)
            wakeup_timer_pending <= 1'b0;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_wd_fire;
        wd_ovf && cfg.wd_rst_en;
    endsequence

    // reset held while a source is active
    rst_held_a: assert property (@(posedge clk) disable iff (!nrst) any_rst |-> !sys_rst_n)
        else $error("reset released while source active");
    // watchdog overflow forces reset next cycles
    wd_reset_a: assert property (@(posedge clk) disable iff (!nrst) s_wd_fire |=> !sys_rst_n[*8])
        else $error("watchdog overflow without reset");
    to_set_a: assert property (@(posedge clk) disable iff (!nrst) s_wd_fire |=> time_out_flag)
        else $error("time-out flag not set");
    // power-down set after sleep from run
    pd_set_a: assert property (@(posedge clk) disable iff (!nrst)
        sleep_instr && mode == RCWC_RUN |=> power_down_flag && sleeping)
        else $error("power-down flag or sleep missing");
    pend_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        wakeup_timer_pending && pending_write && pending_wdata |=> wakeup_timer_pending)
        else $error("pending cleared by write of one");
    // sleep with irq off stops timer, so no overflow can follow
    sleep_stop_a: assert property (@(posedge clk) disable iff (!nrst)
        sleeping && !wakeup_timer_irq_enable |-> !timer_run ##1 !wd_ovf)
        else $error("timer running in sleep without irq enable");
    // run mode with either enable runs timer
    run_timer_a: assert property (@(posedge clk) disable iff (!nrst)
        mode == RCWC_RUN && (cfg.wd_rst_en || wakeup_timer_irq_enable) |-> timer_run)
        else $error("timer stopped in normal mode");
    // low pin with enable gives reset within three cycles
    pin_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        cfg.pin_rst_en && !reset_pin_n [*3] |-> ##[0:1] !sys_rst_n)
        else $error("pin low did not reset");
    wake_irq_a: assert property (@(posedge clk) disable iff (!nrst)
        sleeping && sys_rst_n && !any_rst && ext_irq_pending && ext_irq_enable |=> !sleeping)
        else $error("enabled interrupt did not wake");
endmodule

// File: rtl/rcwc_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
module rcwc_sync
    import rcwc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta; // first stage, read only by q

    // two stages; reset value high suits active-low pins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// File: rtl/rcwc_timer.sv
// shared watchdog and wakeup timer
`timescale 1ns/1ns
`include "rcwc_cfg.svh"
module rcwc_timer
    import rcwc_pkg::*;
#(
    parameter int SHORT_CYC = `RCWC_T_SHORT_US * `RCWC_CLK_MHZ,
    parameter int LONG_CYC = `RCWC_T_LONG_US * `RCWC_CLK_MHZ
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic long_period,
    // overflow pulse
    output logic overflow
);
    logic [20:0] count; // fits 1.31e6 cycles

    // count while running; clear has priority, wrap on overflow
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 21'h0;
            overflow <= 1'b0;
        end
        else if (clear)
        begin
            count <= 21'h0;
            overflow <= 1'b0;
        end
        else if (run)
        begin
            if (count == 21'(long_period ? LONG_CYC - 1 : SHORT_CYC - 1))
            begin
                count <= 21'h0;
                overflow <= 1'b1;
            end
            else
            begin
                count <= count + 21'h1;
                overflow <= 1'b0;
            end
        end
        else
        begin
            overflow <= 1'b0;
        end
    end
endmodule
